/* File: apsc_top.sv */
// Purpose: processor power-state sequencer (Normal to deep_sleep_extended)
// Assumes: stop-clock packets already decoded to one-cycle pulses
// Notes:   mclk stays alive in every state; gated domains are outputs
`timescale 1ns/1ns
module apsc_top
    import apsc_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             haltExec,
    input  wire logic             stpclkAssert,
    input  wire logic             stpclkDeassert,
    input  wire logic [2:0]       smafCode,
    input  wire logic [INT_W-1:0] intPulse,
    input  wire logic             snoopReq,
    input  wire logic             boardReset_n,
    input  wire logic             ref_clk_in,
    input  wire logic             coreSupplyLow,
    input  wire logic             dvfsAtMin,
    input  wire logic             vidWrite,
    input  wire logic [VID_W-1:0] vidValue,
    output wire logic [2:0]       powerState,
    output wire logic             coreClkEn,
    output wire logic             ifClkEn,
    output wire logic             pllEnable,
    output wire logic             sdramPowerSave,
    output wire logic             sdramSelfRefresh,
    output wire logic             snoopAck,
    output wire logic [INT_W-1:0] intService,
    output wire logic             initBusy,
    output wire logic             acpiHandover,
    output wire logic [VID_W-1:0] core_vid_out
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pinSync;
    logic       rstSync_n;
    logic       refSync;
    logic       supLowSync;

    apsc_sync3 u_sync (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .pinIn  ({coreSupplyLow, ref_clk_in, boardReset_n}),
        .pinOut (pinSync)
    );

    assign rstSync_n  = pinSync[0];
    assign refSync    = pinSync[1];
    assign supLowSync = pinSync[2];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        apsc_state_type   st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] refIdle;
        logic             refPrev;
        logic             refActive;
        logic [INT_W-1:0] intPend;
        logic [INT_W-1:0] intAck;
        logic             snoopAck;
        logic [VID_W-1:0] vid;
        logic             handover;
        logic             coreClkEn;
        logic             ifClkEn;
        logic             pllEn;
        logic             powerSave;
        logic             selfRef;
        logic             busy;
    } apsc_ctl_type;

    apsc_ctl_type s_reg;
    apsc_ctl_type s_next;

    logic rstTake;
    logic acceptStop;

    // reset only counts while the reference clock is seen moving
    assign rstTake    = !rstSync_n && s_reg.refActive;
    assign acceptStop = (s_reg.st == ST_NORMAL) || (s_reg.st == ST_HALT);

    function automatic logic snoopOk(input apsc_state_type st);
        snoopOk = (st == ST_NORMAL) || (st == ST_HALT) || (st == ST_QUICK);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next          = s_reg;
        s_next.refPrev  = refSync;
        s_next.snoopAck = snoopReq && snoopOk(s_reg.st);
        s_next.handover = dvfsAtMin;
        if (vidWrite) begin
            s_next.vid = vidValue;
        end

        // activity detector on the synchronised reference clock
        if (refSync != s_reg.refPrev) begin
            s_next.refIdle   = CNT_W'(REF_IDLE_CYC);
            s_next.refActive = 1'b1;
        end else if (s_reg.refIdle != '0) begin
            s_next.refIdle = s_reg.refIdle - 1'b1;
        end else begin
            s_next.refActive = 1'b0;
        end

        if (s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - 1'b1;
        end

        if (rstTake) begin
            s_next.st  = ST_INIT;
            s_next.cnt = CNT_W'(INIT_CYCLES);
        end else begin
            case (s_reg.st)
                ST_INIT: begin
                    if (s_reg.cnt == '0) begin
                        s_next.st = ST_NORMAL;
                    end
                end
                ST_NORMAL, ST_HALT: begin
                    if (stpclkAssert && smafCode == SMAF_C2) begin
                        s_next.st = ST_QUICK;
                    end else if (stpclkAssert && smafCode == SMAF_C3) begin
                        s_next.st = ST_DEEP;
                    end else if (s_reg.st == ST_HALT && (intPulse | s_reg.intPend) != '0) begin
                        s_next.st = ST_NORMAL;
                    end else if (s_reg.st == ST_NORMAL && haltExec) begin
                        s_next.st = ST_HALT;
                    end
                end
                ST_QUICK: begin
                    if (stpclkDeassert) begin
                        s_next.st = ST_NORMAL;
                    end
                end
                ST_DEEP: begin
                    if (supLowSync) begin
                        s_next.st = ST_DSX;
                    end else if (stpclkDeassert) begin
                        s_next.st  = ST_RELOCK;
                        s_next.cnt = CNT_W'(RELOCK_CYCLES);
                    end
                end
                ST_DSX: begin
                    // a deassert here is dropped, not held; only the supply coming back up exits to ST_DEEP
                    if (!supLowSync) begin
                        s_next.st = ST_DEEP;
                    end
                end
                ST_RELOCK: begin
                    if (s_reg.cnt == '0) begin
                        s_next.st = ST_NORMAL;
                    end
                end
                default: begin
                    s_next.st = ST_INIT;
                end
            endcase
        end

        // interrupt handling follows the state being entered
        case (s_next.st)
            ST_NORMAL: begin
                // pulse in the service cycle is acked, never lost
                s_next.intAck  = s_reg.intPend | intPulse;
                s_next.intPend = '0;
            end
            ST_HALT, ST_QUICK: begin
                // one bit per line: repeats fold into it
                s_next.intAck  = '0;
                s_next.intPend = s_reg.intPend | intPulse;
            end
            default: begin
                // deep states and init drop everything
                s_next.intAck  = '0;
                s_next.intPend = '0;
            end
        endcase

        // gating outputs aligned with the registered state
        s_next.coreClkEn = (s_next.st == ST_NORMAL);
        s_next.ifClkEn   = (s_next.st != ST_DEEP) && (s_next.st != ST_DSX)
                           && (s_next.st != ST_RELOCK);
        s_next.pllEn     = (s_next.st != ST_DEEP) && (s_next.st != ST_DSX);
        s_next.powerSave = (s_next.st == ST_QUICK);
        s_next.selfRef   = (s_next.st == ST_DEEP) || (s_next.st == ST_DSX)
                           || (s_next.st == ST_RELOCK);
        s_next.busy      = (s_next.st == ST_INIT);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg           <= '0;
            s_reg.st        <= ST_INIT;
            s_reg.cnt       <= CNT_W'(INIT_CYCLES);
            s_reg.vid       <= VID_RST;
            s_reg.ifClkEn   <= 1'b1;
            s_reg.pllEn     <= 1'b1;
            s_reg.busy      <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign powerState       = s_reg.st;
    assign coreClkEn        = s_reg.coreClkEn;
    assign ifClkEn          = s_reg.ifClkEn;
    assign pllEnable        = s_reg.pllEn;
    assign sdramPowerSave   = s_reg.powerSave;
    assign sdramSelfRefresh = s_reg.selfRef;
    assign snoopAck         = s_reg.snoopAck;
    assign intService       = s_reg.intAck;
    assign initBusy         = s_reg.busy;
    assign acpiHandover     = s_reg.handover;
    assign core_vid_out     = s_reg.vid;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_haltCmd;
        s_reg.st == ST_NORMAL && haltExec && !rstTake && !stpclkAssert;
    endsequence
    sequence s_stopC2;
        acceptStop && stpclkAssert && smafCode == SMAF_C2 && !rstTake;
    endsequence
    sequence s_stopC3;
        acceptStop && stpclkAssert && smafCode == SMAF_C3 && !rstTake;
    endsequence

    property p_halt_entry;
        s_haltCmd |=> s_reg.st == ST_HALT && !coreClkEn && ifClkEn && pllEnable;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");

    property p_halt_wake;
        s_reg.st == ST_HALT && intPulse != '0 && !rstTake && !stpclkAssert
        |=> s_reg.st == ST_NORMAL && intService == ($past(s_reg.intPend) | $past(intPulse));
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt wake wrong");

    property p_snoop_live;
        snoopReq && snoopOk(s_reg.st) |=> snoopAck;
    endproperty
    a_snoop_live: assert property (p_snoop_live) else $error("snoop not acked");

    property p_quick_entry;
        s_stopC2 |=> s_reg.st == ST_QUICK && sdramPowerSave && !coreClkEn;
    endproperty
    a_quick_entry: assert property (p_quick_entry) else $error("quick start missed");

    property p_quick_hold;
        s_reg.st == ST_QUICK && intPulse[0] && !rstTake && !stpclkDeassert
        |=> s_reg.intPend[0] && intService == '0;
    endproperty
    a_quick_hold: assert property (p_quick_hold) else $error("quick int not held");

    property p_quick_exit;
        s_reg.st == ST_QUICK && stpclkDeassert && !rstTake
        |=> s_reg.st == ST_NORMAL && intService == ($past(s_reg.intPend) | $past(intPulse));
    endproperty
    a_quick_exit: assert property (p_quick_exit) else $error("pending int lost");

    property p_init_done;
        s_reg.st == ST_INIT ##1 s_reg.st != ST_INIT |-> s_reg.st == ST_NORMAL;
    endproperty
    a_init_done: assert property (p_init_done) else $error("init exit wrong");

    property p_deep_entry;
        s_stopC3 |=> s_reg.st == ST_DEEP && !pllEnable && sdramSelfRefresh && !ifClkEn;
    endproperty
    a_deep_entry: assert property (p_deep_entry) else $error("deep sleep wrong");

    property p_pll_off;
        s_reg.st == ST_DEEP || s_reg.st == ST_DSX |-> !pllEnable && !coreClkEn;
    endproperty
    a_pll_off: assert property (p_pll_off) else $error("pll on in deep");

    property p_deep_deaf;
        (s_reg.st == ST_DEEP || s_reg.st == ST_DSX) && snoopReq
        |=> !snoopAck ##1 intService == '0;
    endproperty
    a_deep_deaf: assert property (p_deep_deaf) else $error("deep serviced");

    property p_reset_idle;
        !s_reg.refActive && s_reg.st != ST_INIT |=> s_reg.st != ST_INIT;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("reset not ignored");

    property p_dsx_entry;
        s_reg.st == ST_DEEP && supLowSync && !rstTake |=> s_reg.st == ST_DSX && !pllEnable;
    endproperty
    a_dsx_entry: assert property (p_dsx_entry) else $error("dsx missed");

    property p_relock;
        s_reg.st == ST_DEEP && stpclkDeassert && !supLowSync && !rstTake
        |=> (s_reg.st == ST_RELOCK && pllEnable && !coreClkEn) [*8];
    endproperty
    a_relock: assert property (p_relock) else $error("relock too short");

    property p_vid;
        vidWrite |=> core_vid_out == $past(vidValue);
    endproperty
    a_vid: assert property (p_vid) else $error("vid not loaded");

endmodule

/* File: apsc_pkg.sv */
// Purpose: constants and types for the processor power-state controller
// Assumes: mclk at 25 MHz; all times in ns
// Notes:   one package shared by the controller and its pin synchroniser
package apsc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int INIT_TIME_NS   = 400;
    localparam int INIT_CYCLES    = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELOCK_TIME_NS = 2000;
    localparam int RELOCK_CYCLES  = (RELOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_IDLE_NS    = 200;
    localparam int REF_IDLE_CYC   = REF_IDLE_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // widths, codes, reset values
    // ----------------------------------------------------------------
    localparam int CNT_W = 8;
    localparam int INT_W = 8;
    localparam int VID_W = 5;
    localparam logic [2:0]       SMAF_C2      = 3'h2;
    localparam logic [2:0]       SMAF_C3      = 3'h3;
    localparam logic [VID_W-1:0] VID_RST      = 5'h00;
    localparam logic [2:0]       SYNC_RST_VAL = 3'h1;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_NORMAL,
        ST_HALT,
        ST_QUICK,
        ST_DEEP,
        ST_DSX,
        ST_RELOCK
    } apsc_state_type;

endpackage

/* File: apsc_sync3.sv */
// Purpose: three-stage synchroniser for pins of the power controller
// Assumes: inputs asynchronous to mclk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ns
module apsc_sync3
    import apsc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [2:0] pinIn,
    output wire logic [2:0] pinOut
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] f1;
        logic [2:0] f2;
        logic [2:0] f3;
        logic [2:0] q;
    } apsc_sync_type;

    apsc_sync_type s_reg;
    apsc_sync_type s_next;

    always_comb begin
        s_next    = s_reg;
        s_next.f1 = pinIn;
        s_next.f2 = s_reg.f1;
        s_next.f3 = s_reg.f2;
        // glitch filter: stage one is never looked at here
        for (int i = 0; i < 3; i++) begin
            if (s_reg.f2[i] == s_reg.f3[i]) begin
                s_next.q[i] = s_reg.f3[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= {4{SYNC_RST_VAL}};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pinOut = s_reg.q;

endmodule

/* File: apsc_sb_model.sv */
// Purpose: southbridge model issuing decoded stop-clock packets
// Assumes: packets arrive as one-cycle pulses on mclk
// Notes:   smafCode shows the inverse of its last value between packets
`timescale 1ns/1ns
module apsc_sb_model
    import apsc_pkg::*;
(
    input  wire logic       mclk,
    output logic            stpclkAssert,
    output logic            stpclkDeassert,
    output logic [2:0]      smafCode,
    output logic            linkHalt_n
);
    int   quietCnt = 0;
    logic guardArm;

    initial begin
        stpclkAssert   = 1'b0;
        stpclkDeassert = 1'b0;
        smafCode       = 3'h0;
        linkHalt_n     = 1'b1;
        guardArm       = 1'b0;
    end

    // ----------------------------------------------------------------
    // relock guard
    // ----------------------------------------------------------------
    // armed by the deassert packet so only this process writes the count
    always @(posedge mclk) begin
        if (guardArm) begin
            quietCnt <= RELOCK_CYCLES;
        end else if (quietCnt > 0) begin
            quietCnt <= quietCnt - 1;
        end
    end

    // ----------------------------------------------------------------
    // packets
    // ----------------------------------------------------------------
    task automatic sendAssert(input logic [2:0] code);
        while (quietCnt != 0) @(posedge mclk);
        @(posedge mclk);
        stpclkAssert <= 1'b1;
        smafCode     <= code;
        if (code == SMAF_C3) begin
            linkHalt_n <= 1'b0;
        end
        @(posedge mclk);
        stpclkAssert <= 1'b0;
        smafCode     <= ~code;
    endtask

    task automatic sendDeassert();
        @(posedge mclk);
        stpclkDeassert <= 1'b1;
        linkHalt_n     <= 1'b1;
        guardArm       <= 1'b1;
        @(posedge mclk);
        stpclkDeassert <= 1'b0;
        guardArm       <= 1'b0;
    endtask
endmodule

/* File: apsc_testbench.sv */
// Purpose: self-checking bench for the power-state sequencer
// Assumes: ref clock toggles every two mclk cycles while running
// Notes:   stimulus by non-blocking assignment at the rising edge
`timescale 1ns/1ns
module testbench;
    import apsc_pkg::*;
    logic             mclk, rst_n, haltExec, snoopReq, boardReset_n;
    logic             coreSupplyLow, dvfsAtMin, vidWrite, refRun;
    logic [1:0]       refDiv = 2'h0;
    logic [7:0]       intPulse;
    logic [4:0]       vidValue;
    wire              stpA, stpD, ref_clk_in, linkHalt_n;
    wire  [2:0]       smaf, powerState;
    wire              coreClkEn, ifClkEn, pllEnable, sdramPowerSave, sdramSelfRefresh;
    wire              snoopAck, initBusy, acpiHandover;
    wire  [7:0]       intService;
    wire  [4:0]       core_vid_out;
    int               nErrors, numChecks;

    apsc_sb_model u_sb (.mclk(mclk), .stpclkAssert(stpA), .stpclkDeassert(stpD),
        .smafCode(smaf), .linkHalt_n(linkHalt_n));
    apsc_top u_dut (.mclk(mclk), .rst_n(rst_n), .haltExec(haltExec), .stpclkAssert(stpA),
        .stpclkDeassert(stpD), .smafCode(smaf), .intPulse(intPulse), .snoopReq(snoopReq),
        .boardReset_n(boardReset_n), .ref_clk_in(ref_clk_in), .coreSupplyLow(coreSupplyLow),
        .dvfsAtMin(dvfsAtMin), .vidWrite(vidWrite), .vidValue(vidValue),
        .powerState(powerState), .coreClkEn(coreClkEn), .ifClkEn(ifClkEn),
        .pllEnable(pllEnable), .sdramPowerSave(sdramPowerSave),
        .sdramSelfRefresh(sdramSelfRefresh), .snoopAck(snoopAck), .intService(intService),
        .initBusy(initBusy), .acpiHandover(acpiHandover), .core_vid_out(core_vid_out));

    // ----------------------------------------------------------------
    // clocks
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
    end
    // slow ref clock so the sampled copy always shows movement
    always @(posedge mclk) if (refRun) refDiv <= refDiv + 2'h1;
    assign ref_clk_in = refDiv[1];

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nErrors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic st(input apsc_state_type e); chk(8'(powerState), 8'(e)); endtask
    task automatic cyc(input int n); repeat (n) @(posedge mclk); #1; endtask
    task automatic waitSt(input apsc_state_type e, input int lim);
        int k;
        k = 0;
        while (powerState !== e && k < lim) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic pulse(input logic h, input logic s, input logic [7:0] i);
        @(posedge mclk);
        haltExec <= h;
        snoopReq <= s;
        intPulse <= i;
        @(posedge mclk);
        haltExec <= 1'b0;
        snoopReq <= 1'b0;
        intPulse <= 8'h00;
        #1;
    endtask
    task automatic summarize();
        if (nErrors == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic tHalt();
        pulse(1'b1, 1'b0, 8'h00);
        st(ST_HALT);
        chk(8'(coreClkEn), 8'h00);
        chk(8'(ifClkEn), 8'h01);
        pulse(1'b0, 1'b1, 8'h00);
        chk(8'(snoopAck), 8'h01);
        pulse(1'b0, 1'b0, 8'h04);
        st(ST_NORMAL);
        chk(intService, 8'h04);
        // interrupt on the halt cycle itself still wakes the core
        pulse(1'b1, 1'b0, 8'h02);
        cyc(1);
        st(ST_NORMAL);
        chk(intService, 8'h02);
    endtask
    task automatic tQuick();
        u_sb.sendAssert(SMAF_C2);
        #1;
        st(ST_QUICK);
        chk(8'(sdramPowerSave), 8'h01);
        pulse(1'b0, 1'b1, 8'h01);
        chk(8'(snoopAck), 8'h01);
        chk(intService, 8'h00);
        pulse(1'b0, 1'b0, 8'h01);
        pulse(1'b0, 1'b0, 8'h10);
        u_sb.sendDeassert();
        #1;
        st(ST_NORMAL);
        chk(8'(sdramPowerSave), 8'h00);
        chk(intService, 8'h11);
        cyc(1);
        chk(intService, 8'h00);
    endtask
    task automatic tDeep();
        u_sb.sendAssert(SMAF_C3);
        #1;
        st(ST_DEEP);
        chk(8'(linkHalt_n), 8'h00);
        chk(8'(pllEnable), 8'h00);
        chk({sdramSelfRefresh, ifClkEn, coreClkEn}, 8'h04);
        pulse(1'b0, 1'b1, 8'h80);
        chk(8'(snoopAck), 8'h00);
        @(posedge mclk);
        coreSupplyLow <= 1'b1;
        waitSt(ST_DSX, 8);
        st(ST_DSX);
        chk({pllEnable, sdramSelfRefresh}, 8'h01);
        u_sb.sendDeassert();
        #1;
        st(ST_DSX);
        @(posedge mclk);
        coreSupplyLow <= 1'b0;
        waitSt(ST_DEEP, 8);
        st(ST_DEEP);
        u_sb.sendDeassert();
        #1;
        st(ST_RELOCK);
        chk(8'(pllEnable), 8'h01);
        cyc(50);
        st(ST_RELOCK);
        cyc(1);
        st(ST_NORMAL);
        chk({sdramSelfRefresh, ifClkEn, coreClkEn}, 8'h03);
        chk(intService, 8'h00);
    endtask
    task automatic tBoard();
        pulse(1'b1, 1'b0, 8'h00);
        u_sb.sendAssert(SMAF_C2);
        #1;
        st(ST_QUICK);
        @(posedge mclk);
        boardReset_n <= 1'b0;
        waitSt(ST_INIT, 8);
        chk(8'(initBusy), 8'h01);
        @(posedge mclk);
        boardReset_n <= 1'b1;
        waitSt(ST_NORMAL, 20);
        st(ST_NORMAL);
        chk(8'(initBusy), 8'h00);
        @(posedge mclk);
        refRun <= 1'b0;
        cyc(12);
        @(posedge mclk);
        boardReset_n <= 1'b0;
        cyc(10);
        st(ST_NORMAL);
        @(posedge mclk);
        boardReset_n <= 1'b1;
        cyc(6);
        @(posedge mclk);
        refRun <= 1'b1;
        cyc(6);
    endtask
    task automatic tMisc();
        u_sb.sendAssert(3'h5);
        #1;
        st(ST_NORMAL);
        @(posedge mclk);
        dvfsAtMin <= 1'b1;
        cyc(1);
        chk(8'(acpiHandover), 8'h01);
        @(posedge mclk);
        dvfsAtMin <= 1'b0;
        vidWrite  <= 1'b1;
        vidValue  <= 5'h15;
        @(posedge mclk);
        vidWrite  <= 1'b0;
        vidValue  <= 5'h0A;
        #1;
        chk(8'(acpiHandover), 8'h00);
        chk(8'(core_vid_out), 8'h15);
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        {rst_n, haltExec, snoopReq, coreSupplyLow, dvfsAtMin, vidWrite} = 6'h00;
        {boardReset_n, refRun} = 2'h3;
        intPulse  = 8'h00;
        vidValue  = 5'h00;
        nErrors   = 0;
        numChecks = 0;
        cyc(2);
        st(ST_INIT);
        chk({ifClkEn, pllEnable, coreClkEn}, 8'h06);
        chk(8'(initBusy), 8'h01);
        // third edge still sees reset low; release lands with it
        @(posedge mclk);
        rst_n <= 1'b1;
        cyc(5);
        st(ST_INIT);
        cyc(5);
        st(ST_INIT);
        cyc(1);
        st(ST_NORMAL);
        chk(8'(coreClkEn), 8'h01);
        tHalt();
        tQuick();
        tDeep();
        tBoard();
        tMisc();
        summarize();
    end
    initial begin
        #(20000 * CLK_PERIOD_NS);
        nErrors++;
        summarize();
    end
endmodule
